// >>> src/trap_bus_pkg.sv
package trap_bus_pkg;

  typedef enum logic [5:0] {
    BUS_IDLE = 6'b000001,
    BUS_T1 = 6'b000010,
    BUS_T2 = 6'b000100,
    BUS_TW = 6'b001000,
    BUS_T3 = 6'b010000,
    BUS_HOLD = 6'b100000
  } bus_state_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic write;
    logic io;
    logic fetch;
  } bus_req_s;

  typedef struct packed {
    logic [7:0] addr_hi;
    logic [7:0] ad_out;
    logic ad_oe;
    logic ctl_oe;
    logic ale;
    logic rd_n;
    logic wr_n;
    logic int_ack_n;
    logic io_m;
    logic hlda;
  } bus_pins_s;

  typedef struct packed {
    logic valid;
    logic is_intr;
    logic [15:0] vector;
    logic [15:0] resume_addr;
  } vec_s;

endpackage

// >>> src/trap_bus_regs.svh
`ifndef TRAP_BUS_REGS_SVH
`define TRAP_BUS_REGS_SVH

// Restart targets
`define TB_VEC_TRAP 16'h0024
`define TB_VEC_R55 16'h002C
`define TB_VEC_R65 16'h0034
`define TB_VEC_R75 16'h003C
`define TB_VEC_NONE 16'h0000
`define TB_RESUME_STEP 16'h0001

// Read-mask result layout
`define TB_MREAD_MASK_LO 0
`define TB_MREAD_IE_BIT 3
`define TB_MREAD_P55_BIT 4
`define TB_MREAD_P65_BIT 5
`define TB_MREAD_P75_BIT 6
`define TB_MREAD_SERIN_BIT 7

// Positions in the pin synchroniser word
`define TB_PIN_TRAP 0
`define TB_PIN_R55 1
`define TB_PIN_R65 2
`define TB_PIN_R75 3
`define TB_PIN_INTR 4
`define TB_PIN_HOLD 5
`define TB_PIN_READY 6
`define TB_PIN_SERIN 7
`define TB_PIN_AD_LO 8

// Mask input bits
`define TB_MASK_R55 0
`define TB_MASK_R65 1
`define TB_MASK_R75 2

// Oscillator divided by two: the processor cycle ends when phase is high
`define TB_PHASE_LAST 1'b1
`define TB_PHASE_FIRST 1'b0

// Serial output reset value; zero byte returned as read data after a write cycle
`define TB_SEROUT_RESET 1'b1
`define TB_BYTE_ZERO 8'h00

`endif

// >>> src/trap_bus_unit.sv
`timescale 1ns/100ps
`include "trap_bus_regs.svh"
// Summary of operation
// - The trap request is taken whatever the interrupt enable flag holds.
// - Taking a trap copies the enable flag into the saved flag, then clears it.
// - First read-mask after a trap reports the saved flag in result bit 3.
// - Later read-mask reports the live flag; read-mask never changes the flag.
// - Bit 3 reads 1 when interrupts are enabled, 0 when disabled.
// - A trap acts like an internal restart to address 24 hex.
// - Return point is the address after the interrupted instruction.
// - Processor clock is the oscillator clock divided by two.
// - Upper address byte on own pins; lower byte shares pins with data.
// - First bus clock drives the full address and pulses address latch strobe.
// - Second and third bus clocks carry data on the shared lower bus.
// - Read, store, memory-or-io and interrupt acknowledge strobes are provided.
// - Hold, ready and interrupt inputs are sampled on the oscillator clock.
// - One serial input line and one serial output line under instruction control.
// - Three maskable restart inputs besides the nonmaskable trap input.
// - After a general interrupt, the next fetch uses acknowledge instead of read.
// - While ready is low, wait cycles are inserted until it returns high.
// - Bus hold request releases the buses once the current machine cycle ends.
module trap_bus_unit
  import trap_bus_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic trap_i,
  input wire logic rst55_i,
  input wire logic rst65_i,
  input wire logic rst75_i,
  input wire logic intr_i,
  input wire logic hold_i,
  input wire logic ready_i,
  input wire logic serial_input_line_i,
  input wire logic [7:0] ad_i,
  input wire logic req_valid_i,
  input wire bus_req_s req_i,
  input wire logic instr_end_i,
  input wire logic [15:0] instr_addr_i,
  input wire logic interrupt_enable_instruction_i,
  input wire logic interrupt_mask_all_instruction_i,
  input wire logic read_interrupt_mask_instruction_i,
  input wire logic [2:0] mask_i,
  input wire logic r75_clr_i,
  input wire logic serout_we_i,
  input wire logic serout_val_i,
  output logic req_ready_o,
  output logic ack_o,
  output logic [7:0] rdata_o,
  output logic [7:0] mask_read_o,
  output vec_s vec_o,
  output bus_pins_s pins_o,
  output logic proc_clk_o,
  output logic serial_output_line_o
);

  typedef struct packed {
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic phase;
    bus_state_e bus;
    bus_req_s cur;
    logic cyc_int_ack;
    logic int_ack_pending;
    logic trap_prev;
    logic trap_req;
    logic r75_prev;
    logic r75_req;
    logic interrupt_enable_flag;
    logic saved_enable_flag;
    logic first_read_pending;
    logic ack;
    logic [7:0] rdata;
    logic [7:0] mask_read;
    vec_s vec;
    bus_pins_s pins;
    logic serout;
  } state_s;

  state_s s_reg;
  state_s s_next;

  logic cyc_end;
  logic hold_s;
  logic ready_s;
  logic trap_s;
  logic r75_s;
  logic take_r55;
  logic take_r65;
  logic take_r75;
  logic take_intr;

  // Only the second synchroniser stage is read by logic
  assign hold_s = s_reg.sync2[`TB_PIN_HOLD];
  assign ready_s = s_reg.sync2[`TB_PIN_READY];
  assign trap_s = s_reg.sync2[`TB_PIN_TRAP];
  assign r75_s = s_reg.sync2[`TB_PIN_R75];
  assign cyc_end = (s_reg.phase == `TB_PHASE_LAST);

  // Maskable requests, highest first; trap needs no enable
  assign take_r75 = s_reg.interrupt_enable_flag & s_reg.r75_req & ~mask_i[`TB_MASK_R75];
  assign take_r65 = s_reg.interrupt_enable_flag & s_reg.sync2[`TB_PIN_R65]
    & ~mask_i[`TB_MASK_R65];
  assign take_r55 = s_reg.interrupt_enable_flag & s_reg.sync2[`TB_PIN_R55]
    & ~mask_i[`TB_MASK_R55];
  assign take_intr = s_reg.interrupt_enable_flag & s_reg.sync2[`TB_PIN_INTR];

  assign req_ready_o = (s_reg.bus == BUS_IDLE) & cyc_end & ~hold_s;
  assign ack_o = s_reg.ack;
  assign rdata_o = s_reg.rdata;
  assign mask_read_o = s_reg.mask_read;
  assign vec_o = s_reg.vec;
  assign pins_o = s_reg.pins;
  assign proc_clk_o = s_reg.phase;
  assign serial_output_line_o = s_reg.serout;

  always_comb
  begin
    s_next = s_reg;
    // All pins pass two flip-flops before use
    s_next.sync1 = {ad_i, serial_input_line_i, ready_i, hold_i, intr_i, rst75_i, rst65_i,
      rst55_i, trap_i};
    s_next.sync2 = s_reg.sync1;
    s_next.phase = ~s_reg.phase;
    s_next.ack = 1'b0;
    s_next.vec.valid = 1'b0;
    s_next.trap_prev = trap_s;
    s_next.r75_prev = r75_s;

    // Serial output under instruction control
    if (serout_we_i)
    begin
      s_next.serout = serout_val_i;
    end

    // Edge-held requests; a new edge wins over a clear in the same cycle
    if (r75_clr_i)
    begin
      s_next.r75_req = 1'b0;
    end
    if (r75_s & ~s_reg.r75_prev)
    begin
      s_next.r75_req = 1'b1;
    end

    if (interrupt_enable_instruction_i)
    begin
      s_next.interrupt_enable_flag = 1'b1;
    end
    else if (interrupt_mask_all_instruction_i)
    begin
      s_next.interrupt_enable_flag = 1'b0;
    end

    // Read-mask result; the enable flag is left as is
    if (read_interrupt_mask_instruction_i)
    begin
      s_next.mask_read[`TB_MREAD_MASK_LO +: 3] = mask_i;
      s_next.mask_read[`TB_MREAD_IE_BIT] = s_reg.first_read_pending ? s_reg.saved_enable_flag
        : s_reg.interrupt_enable_flag;
      s_next.mask_read[`TB_MREAD_P55_BIT] = s_reg.sync2[`TB_PIN_R55];
      s_next.mask_read[`TB_MREAD_P65_BIT] = s_reg.sync2[`TB_PIN_R65];
      s_next.mask_read[`TB_MREAD_P75_BIT] = s_reg.r75_req;
      s_next.mask_read[`TB_MREAD_SERIN_BIT] = s_reg.sync2[`TB_PIN_SERIN];
      s_next.first_read_pending = 1'b0;
    end

    if (instr_end_i)
    begin
      s_next.vec.is_intr = 1'b0;
      s_next.vec.resume_addr = instr_addr_i + `TB_RESUME_STEP;
      if (s_reg.trap_req)
      begin
        // Trap is taken whatever the enable flag holds; the flag is saved, then cleared
        s_next.trap_req = 1'b0;
        s_next.saved_enable_flag = s_reg.interrupt_enable_flag;
        s_next.interrupt_enable_flag = 1'b0;
        s_next.first_read_pending = 1'b1;
        s_next.vec.valid = 1'b1;
        s_next.vec.vector = `TB_VEC_TRAP;
      end
      else if (take_r75 | take_r65 | take_r55)
      begin
        s_next.interrupt_enable_flag = 1'b0;
        s_next.vec.valid = 1'b1;
        if (take_r75)
        begin
          s_next.r75_req = 1'b0;
          s_next.vec.vector = `TB_VEC_R75;
        end
        else if (take_r65)
        begin
          s_next.vec.vector = `TB_VEC_R65;
        end
        else
        begin
          s_next.vec.vector = `TB_VEC_R55;
        end
      end
      else if (take_intr)
      begin
        s_next.interrupt_enable_flag = 1'b0;
        s_next.int_ack_pending = 1'b1;
        s_next.vec.valid = 1'b1;
        s_next.vec.is_intr = 1'b1;
        s_next.vec.vector = `TB_VEC_NONE;
      end
    end

    // Trap edge latches a request; the edge wins over acceptance
    if (trap_s & ~s_reg.trap_prev)
    begin
      s_next.trap_req = 1'b1;
    end

    // Bus machine advances once per processor clock
    if (cyc_end)
    begin
      case (s_reg.bus)
        BUS_IDLE:
        begin
          if (hold_s)
          begin
            s_next.bus = BUS_HOLD;
          end
          else if (req_valid_i)
          begin
            s_next.bus = BUS_T1;
            s_next.cur = req_i;
            s_next.cyc_int_ack = s_reg.int_ack_pending & req_i.fetch;
            if (req_i.fetch)
            begin
              s_next.int_ack_pending = 1'b0;
            end
          end
        end
        BUS_T1:
        begin
          s_next.bus = BUS_T2;
        end
        BUS_T2, BUS_TW:
        begin
          s_next.bus = ready_s ? BUS_T3 : BUS_TW;
        end
        BUS_T3:
        begin
          s_next.ack = 1'b1;
          s_next.rdata = s_reg.cur.write ? `TB_BYTE_ZERO
            : s_reg.sync2[`TB_PIN_AD_LO +: 8];
          s_next.bus = hold_s ? BUS_HOLD : BUS_IDLE;
        end
        BUS_HOLD:
        begin
          if (!hold_s)
          begin
            s_next.bus = BUS_IDLE;
          end
        end
        default:
        begin
          s_next.bus = BUS_IDLE;
        end
      endcase
    end

    // Pin outputs follow the next bus state
    s_next.pins.ale = 1'b0;
    s_next.pins.rd_n = 1'b1;
    s_next.pins.wr_n = 1'b1;
    s_next.pins.int_ack_n = 1'b1;
    s_next.pins.ad_oe = 1'b0;
    s_next.pins.ctl_oe = 1'b1;
    s_next.pins.hlda = 1'b0;
    s_next.pins.addr_hi = s_next.cur.addr[15:8];
    s_next.pins.io_m = s_next.cur.io;
    case (s_next.bus)
      BUS_T1:
      begin
        s_next.pins.ale = 1'b1;
        s_next.pins.ad_out = s_next.cur.addr[7:0];
        s_next.pins.ad_oe = 1'b1;
      end
      BUS_T2, BUS_TW, BUS_T3:
      begin
        if (s_next.cur.write)
        begin
          s_next.pins.ad_out = s_next.cur.wdata;
          s_next.pins.ad_oe = 1'b1;
          s_next.pins.wr_n = 1'b0;
        end
        else if (s_next.cyc_int_ack)
        begin
          s_next.pins.int_ack_n = 1'b0;
        end
        else
        begin
          s_next.pins.rd_n = 1'b0;
        end
      end
      BUS_HOLD:
      begin
        s_next.pins.ctl_oe = 1'b0;
        s_next.pins.hlda = 1'b1;
      end
      default:
      begin
        s_next.pins.ad_oe = 1'b0;
      end
    endcase

    if (srst_i)
    begin
      s_next = '0;
      s_next.phase = `TB_PHASE_FIRST;
      s_next.bus = BUS_IDLE;
      s_next.serout = `TB_SEROUT_RESET;
      s_next.pins.rd_n = 1'b1;
      s_next.pins.wr_n = 1'b1;
      s_next.pins.int_ack_n = 1'b1;
      s_next.pins.ctl_oe = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    s_reg <= s_next;
  end

endmodule

// >>> tb/bus_partner.sv
`timescale 1ns/100ps
module bus_partner
  import trap_bus_pkg::*;
(
  input wire logic clk_i,
  input wire bus_pins_s pins_i,
  input wire logic slow_i,
  output logic [7:0] ad_o,
  output logic ready_o
);
  logic [7:0] mem [256];
  logic [7:0] lat_reg = 8'h00;
  logic [7:0] idle_reg = 8'hA5;
  logic [3:0] wait_reg = 4'h0;
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'hC3;
  end
  // Released bus toggles so a stale byte never looks valid
  assign ad_o = (pins_i.rd_n && pins_i.int_ack_n) ? idle_reg : mem[lat_reg];
  assign ready_o = !(slow_i && (pins_i.ale || wait_reg != 4'h0));
  always @(posedge clk_i)
  begin
    idle_reg <= ~idle_reg;
    if (pins_i.ale)
    begin
      lat_reg <= pins_i.ad_out;
      wait_reg <= 4'hA;
    end
    else if (wait_reg != 4'h0)
      wait_reg <= wait_reg - 4'h1;
    if (!pins_i.wr_n)
      mem[lat_reg] <= pins_i.ad_out;
  end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import trap_bus_pkg::*;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic trap_i = 1'b0;
  logic hold_i = 1'b0;
  logic serin = 1'b0;
  logic r55 = 1'b0;
  logic r65 = 1'b0;
  logic r75 = 1'b0;
  logic intr = 1'b0;
  logic fch = 1'b0;
  logic slow = 1'b0;
  logic pclk;
  logic req_valid_i = 1'b0;
  logic [5:0] ops = 6'h00;
  logic [2:0] msk = 3'h0;
  logic [15:0] iaddr = 16'h0000;
  bus_req_s req_i = '0;
  wire logic ready_i;
  wire logic [7:0] ad_i;
  logic req_ready_o;
  logic ack_o;
  logic proc_clk_o;
  logic serout;
  logic [7:0] rdata_o;
  logic [7:0] mask_read_o;
  vec_s vec_o;
  bus_pins_s pins_o;
  int miscompares = 0;
  int comparisons = 0;
  int ack_cnt = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  trap_bus_unit i_trap_bus_unit (.ref_clk_i, .srst_i, .trap_i, .rst55_i(r55),
    .rst65_i(r65), .rst75_i(r75), .intr_i(intr), .hold_i, .ready_i,
    .serial_input_line_i(serin), .ad_i, .req_valid_i, .req_i, .instr_end_i(ops[3]),
    .instr_addr_i(iaddr), .interrupt_enable_instruction_i(ops[0]),
    .interrupt_mask_all_instruction_i(ops[1]), .read_interrupt_mask_instruction_i(ops[2]),
    .mask_i(msk), .r75_clr_i(1'b0), .serout_we_i(ops[4]), .serout_val_i(ops[5]),
    .req_ready_o, .ack_o, .rdata_o, .mask_read_o, .vec_o, .pins_o, .proc_clk_o,
    .serial_output_line_o(serout));
  bus_partner i_bus_partner (.clk_i(ref_clk_i), .pins_i(pins_o), .slow_i(slow),
    .ad_o(ad_i), .ready_o(ready_i));
  // Counts clocks with the acknowledge strobe low
  always @(posedge ref_clk_i)
    if (pins_o.int_ack_n === 1'b0)
      ack_cnt <= ack_cnt + 1;
  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic hang();
    miscompares++;
    $display("BAD t=%0t wait ran out", $time);
    tally_and_finish();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic op(input logic [5:0] v);
    @(posedge ref_clk_i);
    ops <= v;
    @(posedge ref_clk_i);
    ops <= 6'h00;
  endtask
  task automatic bus(input logic [15:0] a, input logic [7:0] d, input logic w, output int n);
    @(posedge ref_clk_i);
    req_i <= '{addr: a, wdata: d, write: w, io: 1'b0, fetch: fch};
    req_valid_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (req_ready_o !== 1'b1 && n < 20);
    if (req_ready_o !== 1'b1)
      hang();
    req_valid_i <= 1'b0;
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 40);
    if (ack_o !== 1'b1)
      hang();
  endtask
  task automatic bus_test();
    int n;
    bus(16'h12A5, 8'h5A, 1'b1, n);
    bus(16'h12A5, 8'h00, 1'b0, n);
    chk(16'(rdata_o), 16'h005A);
    bus(16'h3407, 8'h00, 1'b0, n);
    chk(16'(rdata_o), 16'h00C4);
    slow <= 1'b1;
    bus(16'h3407, 8'h00, 1'b0, n);
    chk(16'(rdata_o), 16'h00C4);
    chk(16'(n > 9), 16'h0001);
    slow <= 1'b0;
    $display("bus test done");
  endtask
  task automatic trap_test();
    logic [5:0] post [6] = '{6'h01, 6'h00, 6'h02, 6'h01, 6'h00, 6'h02};
    logic [5:0] e1 = 6'b000111;
    logic [5:0] e2 = 6'b001001;
    for (int i = 0; i < 6; i++)
    begin
      op(i < 3 ? 6'h01 : 6'h02);
      trap_i <= 1'b1;
      iaddr <= 16'h0100 + 16'(i);
      cyc(6);
      op(6'h08);
      trap_i <= 1'b0;
      @(posedge ref_clk_i);
      chk({vec_o.valid, vec_o.is_intr, 14'h0000}, 16'h8000);
      chk(vec_o.vector, 16'h0024);
      chk(vec_o.resume_addr, 16'h0101 + 16'(i));
      op(post[i]);
      op(6'h04);
      @(posedge ref_clk_i);
      chk(16'(mask_read_o[3]), 16'(e1[i]));
      op(6'h04);
      @(posedge ref_clk_i);
      chk(16'(mask_read_o[3]), 16'(e2[i]));
    end
    $display("trap test done");
  endtask
  task automatic serial_test();
    serin <= 1'b1;
    msk <= 3'h5;
    cyc(4);
    op(6'h04);
    @(posedge ref_clk_i);
    chk(16'({mask_read_o[7], mask_read_o[2:0]}), 16'h000D);
    op(6'h10);
    @(posedge ref_clk_i);
    chk(16'(serout), 16'h0000);
    op(6'h30);
    @(posedge ref_clk_i);
    chk(16'(serout), 16'h0001);
    $display("serial test done");
  endtask
  task automatic intr_test();
    int n;
    int k;
    msk <= 3'h0;
    r55 <= 1'b1;
    r75 <= 1'b1;
    op(6'h01);
    cyc(4);
    op(6'h08);
    @(posedge ref_clk_i);
    chk(vec_o.vector, 16'h003C);
    r65 <= 1'b1;
    op(6'h01);
    op(6'h08);
    @(posedge ref_clk_i);
    chk(vec_o.vector, 16'h0034);
    r65 <= 1'b0;
    op(6'h01);
    op(6'h08);
    @(posedge ref_clk_i);
    chk(vec_o.vector, 16'h002C);
    r55 <= 1'b0;
    r75 <= 1'b0;
    intr <= 1'b1;
    op(6'h01);
    cyc(4);
    op(6'h08);
    intr <= 1'b0;
    @(posedge ref_clk_i);
    chk({vec_o.valid, vec_o.is_intr, 14'h0000}, 16'hC000);
    fch <= 1'b1;
    k = ack_cnt;
    bus(16'h0010, 8'h00, 1'b0, n);
    chk(16'(ack_cnt > k), 16'h0001);
    chk(16'(rdata_o), 16'h00D3);
    k = ack_cnt;
    bus(16'h0011, 8'h00, 1'b0, n);
    chk(16'(ack_cnt == k), 16'h0001);
    chk(16'(rdata_o), 16'h00D2);
    fch <= 1'b0;
    $display("intr test done");
  endtask
  task automatic hold_test();
    int n;
    hold_i <= 1'b1;
    for (n = 0; n < 20 && pins_o.hlda !== 1'b1; n++)
      @(posedge ref_clk_i);
    if (pins_o.hlda !== 1'b1)
      hang();
    chk(16'({pins_o.hlda, pins_o.ctl_oe, pins_o.ad_oe}), 16'h0004);
    hold_i <= 1'b0;
    cyc(8);
    chk(16'({pins_o.hlda, pins_o.ctl_oe}), 16'h0001);
    $display("hold test done");
  endtask
  initial
  begin
    cyc(20);
    srst_i <= 1'b0;
    cyc(2);
    chk(16'({serout, pins_o.rd_n, pins_o.wr_n, pins_o.int_ack_n, pins_o.ctl_oe,
      pins_o.hlda}), 16'h003E);
    pclk = proc_clk_o;
    @(posedge ref_clk_i);
    chk(16'(proc_clk_o ^ pclk), 16'h0001);
    bus_test();
    trap_test();
    serial_test();
    intr_test();
    hold_test();
    tally_and_finish();
  end
endmodule

// >>> tb/trap_bus_assertions.sv
`timescale 1ns/100ps
module trap_bus_chk
  import trap_bus_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic req_valid_i,
  input wire bus_req_s req_i,
  input wire logic ready_i,
  input wire logic instr_end_i,
  input wire logic [15:0] instr_addr_i,
  input wire logic req_ready_o,
  input wire logic ack_o,
  input wire vec_s vec_o,
  input wire bus_pins_s pins_o,
  input wire logic proc_clk_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  wire logic take = req_valid_i && req_ready_o;
  property p_div;
    !srst_i ##1 !srst_i |-> proc_clk_o != $past(proc_clk_o);
  endproperty
  a_div: assert property (p_div) else $error("clock not halved");
  property p_take;
    take |=> pins_o.ale && pins_o.ad_oe && pins_o.ad_out == $past(req_i.addr[7:0])
      && pins_o.addr_hi == $past(req_i.addr[15:8]) && pins_o.io_m == $past(req_i.io);
  endproperty
  a_take: assert property (p_take) else $error("bad address phase");
  property p_data;
    $fell(pins_o.ale) |-> pins_o.ad_oe == !pins_o.wr_n;
  endproperty
  a_data: assert property (p_data) else $error("bad data direction");
  property p_strb;
    $fell(pins_o.ale) |-> $onehot({!pins_o.rd_n, !pins_o.wr_n, !pins_o.int_ack_n});
  endproperty
  a_strb: assert property (p_strb) else $error("bad strobe");
  property p_wait;
    take ##2 !ready_i [*5] |-> !ack_o ##1 !ack_o;
  endproperty
  a_wait: assert property (p_wait) else $error("no wait cycles");
  property p_fast;
    take ##1 ready_i [*5] |-> ##[0:2] ack_o;
  endproperty
  a_fast: assert property (p_fast) else $error("cycle too long");
  property p_trap;
    instr_end_i ##1 vec_o.valid && vec_o.vector == 16'h0024
      |-> vec_o.resume_addr == $past(instr_addr_i) + 16'h0001;
  endproperty
  a_trap: assert property (p_trap) else $error("bad return point");
  property p_hold;
    pins_o.hlda |-> !pins_o.ctl_oe && !pins_o.ad_oe && !pins_o.ale;
  endproperty
  a_hold: assert property (p_hold) else $error("bus not released");
endmodule
bind trap_bus_unit trap_bus_chk i_chk (.ref_clk_i, .srst_i, .req_valid_i, .req_i,
  .ready_i, .instr_end_i, .instr_addr_i, .req_ready_o, .ack_o, .vec_o, .pins_o, .proc_clk_o);
